// *** anp_latch.sv ***
// Purpose: Latch-high flags that clear on a management read.
// Assumes: One clear strobe covers every flag.
// Notes:   A set in the clearing cycle keeps its flag high.

`timescale 1ns/1ps

module anp_latch #(
  parameter int N = 2
) (
  input  wire logic clk,
  input  wire logic rst,
  anp_latch_if.owner lf
);

  typedef struct packed {
    logic [N-1:0] flags;
  } anp_latch_type;

  anp_latch_type st;
  anp_latch_type next_st;

  // ---------------------------------------------------------------
  // Flag update
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (lf.clear) begin
      next_st.flags = '0;
    end
    next_st.flags = next_st.flags | lf.set;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign lf.flags = st.flags;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_flag_holds_high: assert property (((lf.flags != '0) && !lf.clear) |=>
      ((lf.flags & $past(lf.flags)) == $past(lf.flags)))
    else $error("A latched flag fell without a clear.");

  a_set_beats_clear: assert property ((lf.clear && (lf.set != '0)) |=>
      ((lf.flags & $past(lf.set)) == $past(lf.set)))
    else $error("A set was lost in the clearing cycle.");

endmodule // anp_latch

// *** anp_latch_if.sv ***
// Purpose: Carries latched status flags between the bank and its flag unit.
// Assumes: Set and clear come from logic on the same clock.
// Notes:   Flags are sticky until cleared.

`timescale 1ns/1ps

interface anp_latch_if #(parameter int N = 2);
  logic [N-1:0] set;
  logic         clear;
  logic [N-1:0] flags;

  modport owner (input set, input clear, output flags);
  modport user  (output set, output clear, input flags);
endinterface

// *** anp_partner.sv ***
// Purpose: Remote link partner that hands received code words to the bank.
// Assumes: Driven at the falling clock edge, one page per call.
// Notes:   Between pages the word lines show the inverse of the last word.

`timescale 1ns/1ps

module anp_partner (
  input  wire logic        clk,
  output logic             rx_page_valid,
  output logic             rx_page_is_base,
  output logic [15:0]      rx_code_word,
  output logic             partner_autoneg_capable
);
  initial begin
    rx_page_valid = 1'b0;
    rx_page_is_base = 1'b0;
    rx_code_word = 16'hffff;
    partner_autoneg_capable = 1'b0;
  end

  // -------------------------------------------------------------
  // Page delivery
  // -------------------------------------------------------------
  task automatic send_page(input logic base, input logic [15:0] word, input logic able);
    @(negedge clk);
    partner_autoneg_capable = able;
    rx_page_valid = 1'b1;
    rx_page_is_base = base;
    rx_code_word = word;
    @(negedge clk);
    rx_page_valid = 1'b0;
    rx_page_is_base = 1'b0;
    rx_code_word = ~word;
  endtask
endmodule // anp_partner

// *** anp_pkg.sv ***
// Purpose: Shared constants and types for the partner page register bank.
// Assumes: Management addresses are five bits and registers are 16 bits.
// Notes:   Bit positions are shared by the base-page and next-page views.

package anp_pkg;

  // ---------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------
  localparam logic [4:0] ADDR_PARTNER   = 5'h05;
  localparam logic [4:0] ADDR_EXPANSION = 5'h06;
  localparam logic [4:0] ADDR_TX_PAGE   = 5'h07;

  // ---------------------------------------------------------------
  // Code word field positions
  // ---------------------------------------------------------------
  localparam int BIT_MORE_PAGES = 15;
  localparam int BIT_ACK        = 14;
  localparam int BIT_FAULT_MSG  = 13;
  localparam int BIT_COMPLY     = 12;
  localparam int BIT_TOGGLE     = 11;
  localparam int TECH_MSB       = 12;
  localparam int TECH_LSB       = 5;
  localparam int SEL_MSB        = 4;
  localparam int CODE_MSB       = 10;
  localparam int CODE_WIDTH     = 11;

  // ---------------------------------------------------------------
  // Expansion register field positions
  // ---------------------------------------------------------------
  localparam int EXP_PAR_FAULT  = 4;
  localparam int EXP_PARTNER_NP = 3;
  localparam int EXP_LOCAL_NP   = 2;
  localparam int EXP_PAGE_RX    = 1;
  localparam int EXP_PARTNER_AN = 0;
  localparam int EXP_RSV_LSB    = 5;

  // ---------------------------------------------------------------
  // Latched flag indices, masks and reset values
  // ---------------------------------------------------------------
  localparam int FLAG_PAR_FAULT = 0;
  localparam int FLAG_PAGE_RX   = 1;
  localparam int FLAG_COUNT     = 2;
  localparam int TECH_COUNT     = 3;

  localparam logic [15:0] TX_PAGE_WMASK = 16'hb7ff;
  localparam logic [15:0] TX_PAGE_RESET = 16'h0000;
  localparam logic [15:0] WORD_RESET    = 16'h0000;
  localparam logic        LOCAL_NP_ABLE = 1'h1;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic {VIEW_BASE, VIEW_NEXT} anp_view_type;

  typedef struct packed {
    anp_view_type view;
    logic         an_done;
    logic [15:0]  base_word;
    logic [15:0]  next_word;
    logic         partner_an;
    logic [15:0]  tx_page;
    logic         ack_bit;
    logic         np_sent;
    logic         toggle;
    logic [15:0]  rdata;
    logic         rvalid;
    logic [15:0]  tx_code;
  } anp_main_type;

endpackage

// *** anp_regs.sv ***
// Purpose: Partner ability, expansion and next-page transmit registers.
// Assumes: Page strobes come from the arbitration logic on the same clock.
// Notes:   Read data appear one cycle after the read strobe.

`timescale 1ns/1ps

// Overview of operation
// - Base bit 15: partner wants next pages
// - Base bit 14: partner acknowledged bursts
// - Base bit 13: partner reports a fault
// - Base bits 12:5: partner technology ability
// - Base bits 4:0: partner selector field
// - Next bit 15: more partner pages follow
// - Next bit 14: partner received our word
// - Next bit 13: message or unformatted page
// - Next bit 12: partner can comply
// - Next bit 11: partner toggle bit
// - Bits 10:0 carry eleven-bit code field
// - Parallel fault latches, cleared by read
// - Fault set on concurrent technology links
// - Expansion bit 3: partner next-page able
// - Expansion bit 2 always reads one
// - Page received latches until read
// - Expansion bit 0 partner autoneg; rest reserved
// - Transmit acknowledge bit is read-only mirror
// - Transmit toggle flips, starts inverted base
// - Registers valid after completion; restart clears done, keeps stored pages
module anp_regs
  import anp_pkg::*;
#(
  parameter int TECHS = TECH_COUNT
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [4:0]       mgmt_addr,
  input  wire logic             mgmt_rd,
  input  wire logic             mgmt_wr,
  input  wire logic [15:0]      mgmt_wdata,
  output logic      [15:0]      mgmt_rdata,
  output logic                  mgmt_rvalid,
  input  wire logic             an_restart,
  input  wire logic             an_complete,
  input  wire logic             rx_page_valid,
  input  wire logic             rx_page_is_base,
  input  wire logic [15:0]      rx_code_word,
  input  wire logic             partner_autoneg_capable,
  input  wire logic [TECHS-1:0] tech_link_ok,
  input  wire logic             local_base_toggle,
  input  wire logic             tx_ack_bit,
  input  wire logic             tx_page_sent,
  output logic      [15:0]      tx_code_word,
  output logic                  autoneg_done
);

  anp_main_type st;
  anp_main_type next_st;

  anp_latch_if #(.N(FLAG_COUNT)) lf ();

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic more_than_one(input logic [TECHS-1:0] v);
    return |(v & (v - TECHS'(1)));
  endfunction

  function automatic logic cur_toggle(input anp_main_type s, input logic base_t);
    return s.np_sent ? s.toggle : ~base_t;
  endfunction

  function automatic logic [15:0] tx_word(input anp_main_type s, input logic base_t);
    logic [15:0] w;
    w = s.tx_page & TX_PAGE_WMASK;
    w[BIT_ACK] = s.ack_bit;
    w[BIT_TOGGLE] = cur_toggle(s, base_t);
    return w;
  endfunction

  // ---------------------------------------------------------------
  // Flag unit
  // ---------------------------------------------------------------
  anp_latch #(
    .N   (FLAG_COUNT)
  ) u_flags (
    .clk (clk),
    .rst (rst),
    .lf  (lf.owner)
  );

  always_comb begin
    lf.set = '0;
    lf.set[FLAG_PAR_FAULT] = more_than_one(tech_link_ok);
    lf.set[FLAG_PAGE_RX] = rx_page_valid;
    lf.clear = mgmt_rd && (mgmt_addr == ADDR_EXPANSION);
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.rvalid = mgmt_rd;
    next_st.ack_bit = tx_ack_bit;
    next_st.partner_an = partner_autoneg_capable;

    if (an_complete) begin
      next_st.an_done = 1'h1;
    end

    if (rx_page_valid) begin
      if (rx_page_is_base) begin
        next_st.base_word = rx_code_word;
      end else begin
        next_st.next_word = rx_code_word;
      end
    end

    unique case (st.view)
      VIEW_BASE: begin
        if (rx_page_valid && !rx_page_is_base) begin
          next_st.view = VIEW_NEXT;
        end
      end
      VIEW_NEXT: begin
        next_st.view = VIEW_NEXT;
      end
    endcase

    if (tx_page_sent) begin
      next_st.toggle = ~cur_toggle(st, local_base_toggle);
      next_st.np_sent = 1'h1;
    end

    if (mgmt_wr && (mgmt_addr == ADDR_TX_PAGE)) begin
      next_st.tx_page = mgmt_wdata & TX_PAGE_WMASK;
    end

    next_st.rdata = WORD_RESET;
    if (mgmt_rd) begin
      unique case (mgmt_addr)
        ADDR_PARTNER: begin
          next_st.rdata = (st.view == VIEW_NEXT) ? st.next_word : st.base_word;
        end
        ADDR_EXPANSION: begin
          next_st.rdata[EXP_PAR_FAULT] = lf.flags[FLAG_PAR_FAULT];
          next_st.rdata[EXP_PARTNER_NP] = st.base_word[BIT_MORE_PAGES];
          next_st.rdata[EXP_LOCAL_NP] = LOCAL_NP_ABLE;
          next_st.rdata[EXP_PAGE_RX] = lf.flags[FLAG_PAGE_RX];
          next_st.rdata[EXP_PARTNER_AN] = st.partner_an;
        end
        ADDR_TX_PAGE: begin
          next_st.rdata = tx_word(st, local_base_toggle);
        end
        default: begin
          next_st.rdata = WORD_RESET;
        end
      endcase
    end

    next_st.tx_code = tx_word(st, local_base_toggle);

    if (an_restart) begin
      next_st.an_done = 1'h0;
      next_st.view = VIEW_BASE;
      next_st.np_sent = 1'h0;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign mgmt_rdata   = st.rdata;
  assign mgmt_rvalid  = st.rvalid;
  assign tx_code_word = st.tx_code;
  assign autoneg_done = st.an_done;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence seq_next_rx;
    rx_page_valid && !rx_page_is_base && !an_restart;
  endsequence

  sequence seq_read_partner;
    mgmt_rd && (mgmt_addr == ADDR_PARTNER) && !rx_page_valid && !an_restart;
  endsequence

  a_next_view_read: assert property (seq_next_rx ##1 seq_read_partner |=>
      (mgmt_rdata == $past(rx_code_word, 2)))
    else $error("Partner address did not show the latest next page.");

  a_base_view_read: assert property (((st.view == VIEW_BASE) && mgmt_rd &&
      (mgmt_addr == ADDR_PARTNER) && !rx_page_valid && !an_restart) |=>
      (mgmt_rdata == $past(st.base_word)))
    else $error("Partner address did not show the base page.");

  a_local_np_able: assert property ((mgmt_rd && (mgmt_addr == ADDR_EXPANSION)) |=>
      mgmt_rvalid && mgmt_rdata[EXP_LOCAL_NP] && (mgmt_rdata[15:EXP_RSV_LSB] == '0))
    else $error("Expansion read showed wrong constant bits.");

  a_par_fault_set: assert property (more_than_one(tech_link_ok) |=>
      lf.flags[FLAG_PAR_FAULT])
    else $error("Concurrent links did not set the parallel fault.");

  a_page_rx_set: assert property (rx_page_valid |=> lf.flags[FLAG_PAGE_RX])
    else $error("Received page did not set its flag.");

  a_toggle_flip: assert property ((tx_page_sent && !an_restart) |=>
      (st.toggle != $past(cur_toggle(st, local_base_toggle))))
    else $error("Transmit toggle did not flip after a page.");

  a_first_toggle: assert property (an_restart ##1 !tx_page_sent [*2] |->
      (tx_code_word[BIT_TOGGLE] == !$past(local_base_toggle)))
    else $error("First next page toggle is not the base inverse.");

  a_ack_mirror: assert property (1'b1 |=>
      (tx_code_word[BIT_ACK] == $past(tx_ack_bit, 2)))
    else $error("Transmit acknowledge does not mirror the device bit.");

  a_tx_write: assert property ((mgmt_wr && (mgmt_addr == ADDR_TX_PAGE)) ##1 !mgmt_wr |=>
      ((tx_code_word & TX_PAGE_WMASK) == ($past(mgmt_wdata, 2) & TX_PAGE_WMASK)))
    else $error("Written transmit page fields did not appear.");

  a_done_restart: assert property (an_restart |=> !autoneg_done)
    else $error("Completion flag survived a restart.");

  a_done_set: assert property ((an_complete && !an_restart) |=> autoneg_done)
    else $error("Completion did not set the done flag.");

  // ---------------------------------------------------------------
  // Register bus checks
  // ---------------------------------------------------------------
  sequence seq_read_exp;
    mgmt_rd && (mgmt_addr == ADDR_EXPANSION);
  endsequence

  sequence seq_read_tx;
    mgmt_rd && (mgmt_addr == ADDR_TX_PAGE);
  endsequence

  a_read_answer: assert property (mgmt_rd |=> mgmt_rvalid)
    else $error("A read strobe got no read valid.");

  a_no_spurious: assert property (!mgmt_rd |=>
      (!mgmt_rvalid && (mgmt_rdata == WORD_RESET)))
    else $error("Read data appeared without a read strobe.");

  a_unmapped_zero: assert property ((mgmt_rd && (mgmt_addr != ADDR_PARTNER) &&
      (mgmt_addr != ADDR_EXPANSION) && (mgmt_addr != ADDR_TX_PAGE)) |=>
      (mgmt_rdata == WORD_RESET))
    else $error("An unmapped address read nonzero.");

  a_exp_fault_bit: assert property (seq_read_exp |=>
      (mgmt_rdata[EXP_PAR_FAULT] == $past(lf.flags[FLAG_PAR_FAULT])))
    else $error("Expansion read lost the parallel fault flag.");

  a_exp_page_bit: assert property (seq_read_exp |=>
      (mgmt_rdata[EXP_PAGE_RX] == $past(lf.flags[FLAG_PAGE_RX])))
    else $error("Expansion read lost the page received flag.");

  a_exp_partner_np: assert property (seq_read_exp |=>
      (mgmt_rdata[EXP_PARTNER_NP] == $past(st.base_word[BIT_MORE_PAGES])))
    else $error("Expansion read lost the partner next-page bit.");

  a_exp_autoneg: assert property (seq_read_exp |=>
      (mgmt_rdata[EXP_PARTNER_AN] == $past(partner_autoneg_capable, 2)))
    else $error("Expansion read lost the partner autoneg bit.");

  a_fault_read_clear: assert property ((lf.clear && !more_than_one(tech_link_ok)) |=>
      !lf.flags[FLAG_PAR_FAULT])
    else $error("Reading the expansion did not clear the parallel fault.");

  a_page_read_clear: assert property ((lf.clear && !rx_page_valid) |=>
      !lf.flags[FLAG_PAGE_RX])
    else $error("Reading the expansion did not clear the page flag.");

  a_tx_read_word: assert property (seq_read_tx |=>
      (mgmt_rdata == tx_code_word))
    else $error("Transmit page read differs from the transmit word.");

  a_tx_refused: assert property ((mgmt_wr && (mgmt_addr != ADDR_TX_PAGE)) |=>
      (st.tx_page == $past(st.tx_page)))
    else $error("A write to another address changed the transmit page.");

  a_base_store: assert property ((rx_page_valid && rx_page_is_base) |=>
      (st.base_word == $past(rx_code_word)))
    else $error("Received base page was not stored.");

  a_code_field_rx: assert property ((rx_page_valid && !rx_page_is_base) |=>
      (st.next_word[CODE_MSB:0] == $past(rx_code_word[CODE_MSB:0])))
    else $error("Received code field was not stored.");

  a_view_restart: assert property (an_restart |=> (st.view == VIEW_BASE))
    else $error("Restart did not return to the base view.");

endmodule // anp_regs

// *** test_autoneg_partner_nextpage_regs.sv ***
// Purpose: Self-checking bench for the partner page register bank.
// Assumes: Inputs change at the falling edge; reads are checked from a queue.
// Notes:   Random words come from a fixed seed.

`timescale 1ns/1ps

module test_autoneg_partner_nextpage_regs
  import anp_pkg::*;
;
  logic        clk, rst, mgmt_rd, mgmt_wr, mgmt_rvalid, an_restart, an_complete;
  logic        rx_page_valid, rx_page_is_base, partner_autoneg_capable, autoneg_done;
  logic        local_base_toggle, tx_ack_bit, tx_page_sent, an, ack, tog, pf;
  logic [4:0]  mgmt_addr;
  logic [2:0]  tech_link_ok;
  logic [15:0] mgmt_wdata, mgmt_rdata, rx_code_word, tx_code_word, base_w, next_w, d, e;
  logic [15:0] exp_q[$];
  int          fail_count, comparisons, seed, i;

  anp_regs dut (.clk(clk), .rst(rst), .mgmt_addr(mgmt_addr), .mgmt_rd(mgmt_rd),
    .mgmt_wr(mgmt_wr), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
    .mgmt_rvalid(mgmt_rvalid), .an_restart(an_restart), .an_complete(an_complete),
    .rx_page_valid(rx_page_valid), .rx_page_is_base(rx_page_is_base),
    .rx_code_word(rx_code_word), .partner_autoneg_capable(partner_autoneg_capable),
    .tech_link_ok(tech_link_ok), .local_base_toggle(local_base_toggle),
    .tx_ack_bit(tx_ack_bit), .tx_page_sent(tx_page_sent),
    .tx_code_word(tx_code_word), .autoneg_done(autoneg_done));

  anp_partner partner (.clk(clk), .rx_page_valid(rx_page_valid),
    .rx_page_is_base(rx_page_is_base), .rx_code_word(rx_code_word),
    .partner_autoneg_capable(partner_autoneg_capable));

  // -------------------------------------------------------------
  // Clock, checking and closing
  // -------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input string name, input logic [15:0] ex, input logic [15:0] got);
    comparisons++;
    if (got !== ex) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, ex, got);
    end
  endtask

  task automatic test_done;
    if (exp_q.size() != 0) begin
      fail_count++;
      $display("Error read queue expected %0d seen %0d", 0, exp_q.size());
    end
    $display("Comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(negedge clk) begin
    if (mgmt_rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("unrequested read data", 16'h0000, 16'h0001);
      end else begin
        check("mgmt_rdata", exp_q.pop_front(), mgmt_rdata);
      end
    end
  end

  initial begin
    #(25 * 5000);
    fail_count++;
    test_done;
  end

  // -------------------------------------------------------------
  // Management access
  // -------------------------------------------------------------
  task automatic rd(input logic [4:0] a, input logic [15:0] ex);
    @(negedge clk);
    mgmt_addr = a;
    mgmt_rd = 1'b1;
    exp_q.push_back(ex);
    @(negedge clk);
    mgmt_rd = 1'b0;
    @(negedge clk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(negedge clk);
    mgmt_addr = a;
    mgmt_wdata = v;
    mgmt_wr = 1'b1;
    @(negedge clk);
    mgmt_wr = 1'b0;
  endtask

  function automatic logic [15:0] exp6(logic f, logic np, logic pr, logic ab);
    return {11'h000, f, np, 1'b1, pr, ab};
  endfunction

  task automatic pulse_sent;
    @(negedge clk);
    tx_page_sent = 1'b1;
    @(negedge clk);
    tx_page_sent = 1'b0;
  endtask

  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  initial begin
    seed = 58564;
    rst = 1'b1;
    {mgmt_rd, mgmt_wr, an_restart, an_complete, tx_ack_bit, tx_page_sent} = 6'h00;
    mgmt_addr = 5'h00;
    mgmt_wdata = 16'h0000;
    tech_link_ok = 3'h0;
    local_base_toggle = 1'($random(seed));
    repeat (12) @(negedge clk);
    rst = 1'b0;
    rd(ADDR_PARTNER, WORD_RESET);
    rd(ADDR_EXPANSION, 16'h0004);
    rd(ADDR_TX_PAGE, {1'b0, 3'h0, ~local_base_toggle, 11'h000});
    rd(5'h03, 16'h0000);
    for (i = 0; i < 3; i++) begin
      base_w = 16'($random(seed));
      base_w[4:0] = 5'h01;
      an = 1'($random(seed));
      partner.send_page(1'b1, base_w, an);
      rd(ADDR_PARTNER, base_w);
      rd(ADDR_EXPANSION, exp6(1'b0, base_w[15], 1'b1, an));
      rd(ADDR_EXPANSION, exp6(1'b0, base_w[15], 1'b0, an));
    end
    for (i = 0; i < 8; i++) begin
      @(negedge clk);
      tech_link_ok = i[2:0];
      @(negedge clk);
      tech_link_ok = 3'h0;
      pf = (i == 3 || i >= 5);
      rd(ADDR_EXPANSION, exp6(pf, base_w[15], 1'b0, an));
      rd(ADDR_EXPANSION, exp6(1'b0, base_w[15], 1'b0, an));
    end
    fork
      partner.send_page(1'b1, base_w, an);
      rd(ADDR_EXPANSION, exp6(1'b0, base_w[15], 1'b0, an));
      begin
        @(negedge clk);
        tech_link_ok = 3'h6;
        @(negedge clk);
        tech_link_ok = 3'h0;
      end
    join
    rd(ADDR_EXPANSION, exp6(1'b1, base_w[15], 1'b1, an));
    rd(ADDR_EXPANSION, exp6(1'b0, base_w[15], 1'b0, an));
    @(negedge clk);
    an_complete = 1'b1;
    @(negedge clk);
    an_complete = 1'b0;
    @(negedge clk);
    check("autoneg_done", 16'h0001, {15'h0000, autoneg_done});
    for (i = 0; i < 4; i++) begin
      next_w = 16'($random(seed));
      fork
        partner.send_page(1'b0, next_w, an);
        begin
          @(negedge clk);
          rd(ADDR_PARTNER, next_w);
        end
      join
      rd(ADDR_EXPANSION, exp6(1'b0, base_w[15], 1'b1, an));
    end
    tog = ~local_base_toggle;
    for (i = 0; i < 4; i++) begin
      d = 16'($random(seed));
      ack = 1'($random(seed));
      tx_ack_bit = ack;
      wr(ADDR_TX_PAGE, d);
      e = {d[15], ack, d[13:12], tog, d[10:0]};
      rd(ADDR_TX_PAGE, e);
      check("tx_code_word", e, tx_code_word);
      wr(ADDR_PARTNER, ~d);
      pulse_sent;
      tog = ~tog;
    end
    wr(ADDR_EXPANSION, 16'hffff);
    rd(ADDR_EXPANSION, exp6(1'b0, base_w[15], 1'b0, an));
    rd(ADDR_PARTNER, next_w);
    @(negedge clk);
    an_restart = 1'b1;
    @(negedge clk);
    an_restart = 1'b0;
    @(negedge clk);
    check("autoneg_done", 16'h0000, {15'h0000, autoneg_done});
    rd(ADDR_PARTNER, base_w);
    rd(ADDR_TX_PAGE, {d[15], ack, d[13:12], ~local_base_toggle, d[10:0]});
    repeat (3) @(negedge clk);
    test_done;
  end
endmodule // test_autoneg_partner_nextpage_regs
